// ### tb/clock_mode_sequencer_asserts.sv
// port checker for the clock mode sequencer
// assumes it is bound to clock_mode_sequencer, one clock domain
`timescale 1ns/1ps

module clock_mode_sequencer_asserts #(
    parameter int SETTLE_CYCLES = 1
) (
    // clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // apb
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pslverr,
    // clock outputs
    input wire clock_mode_pkg::loop_drive_t loop_drive,
    input wire logic [1:0]                  main_clock_select,
    input wire logic [1:0]                  bus_divider,
    input wire logic [2:0]                  bus_div_log2,
    input wire logic [8:0]                  combined_trim_value,
    input wire clock_mode_pkg::clock_mode_t mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic wr_hit = psel && penable && pwrite && pstrb[0];
    logic [7:0] last_wdata;

    // held between writes, so a two-cycle window still sees it
    always_ff @(posedge pclk) begin
        if (wr_hit) last_wdata <= pwdata[7:0];
    end

    chk_trim_reset: assert property ($rose(presetn) |->
        combined_trim_value == 9'h100) else $error("trim reset");
    chk_fine_trim_lsb: assert property (wr_hit &&
        paddr == clock_mode_pkg::OFS_FINE_TRIM
        |=> combined_trim_value[0] == last_wdata[0]) else $error("fine");
    chk_coarse_trim_top: assert property (wr_hit &&
        paddr == clock_mode_pkg::OFS_COARSE_TRIM
        |=> combined_trim_value[8:1] == last_wdata) else $error("coarse");
    chk_bus_div_copy: assert property (wr_hit &&
        paddr == clock_mode_pkg::OFS_CONTROL_TWO
        |-> ##[1:2] bus_divider == last_wdata[7:6]) else $error("bus_divider");
    chk_bus_div_total: assert property (
        bus_div_log2 == {1'b0, bus_divider} + 3'h1) else $error("total");
    chk_fll_bypass_on: assert property (
        mode == clock_mode_pkg::loop_bypassed_internal
        |-> loop_drive.fll_enable) else $error("fll off in bypass");
    chk_low_power_off: assert property (
        mode == clock_mode_pkg::low_power_external
        |-> !loop_drive.fll_enable && !loop_drive.pll_enable)
        else $error("loop on in low power");
    chk_pll_source_on: assert property (
        main_clock_select == 2'h3 |-> loop_drive.pll_enable)
        else $error("pll source while off");
    chk_switch_delayed: assert property (wr_hit &&
        paddr == clock_mode_pkg::OFS_CONTROL_ONE
        |=> $stable(main_clock_select)) else $error("switch too soon");

    cover property (mode == clock_mode_pkg::pll_engaged_external);
    cover property (mode == clock_mode_pkg::low_power_internal);
    cover property (pslverr);
endmodule : clock_mode_sequencer_asserts

bind clock_mode_sequencer clock_mode_sequencer_asserts #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pslverr(pslverr), .loop_drive(loop_drive),
    .main_clock_select(main_clock_select), .bus_divider(bus_divider),
    .bus_div_log2(bus_div_log2),
    .combined_trim_value(combined_trim_value), .mode(mode)
);

// ### tb/tb_top.sv
// testbench for the clock mode sequencer, driven over apb
// assumes the sequencer with a short settle count
`timescale 1ns/1ps

module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v;
    logic pready, pslverr, er, ext_ref_on, high_range, high_gain_select;
    logic fll_lock_pin = 0, pll_lock_pin = 0, osc_init_pin = 0;
    logic crystal_select, ref_is_internal;
    logic [1:0] main_clock_select, bus_divider;
    logic [2:0] bus_div_log2;
    logic [8:0] combined_trim_value;
    clock_mode_pkg::loop_drive_t loop_drive;
    clock_mode_pkg::clock_mode_t mode;
    int fail_count = 0, checks_done = 0;

    always #20 pclk = ~pclk;

    clock_mode_sequencer #(.SETTLE_CYCLES(1)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fll_lock_pin(fll_lock_pin), .pll_lock_pin(pll_lock_pin),
        .osc_init_pin(osc_init_pin), .loop_drive(loop_drive),
        .ext_ref_on(ext_ref_on), .high_range(high_range),
        .high_gain_select(high_gain_select),
        .crystal_select(crystal_select),
        .main_clock_select(main_clock_select),
        .ref_is_internal(ref_is_internal), .bus_divider(bus_divider),
        .bus_div_log2(bus_div_log2),
        .combined_trim_value(combined_trim_value), .mode(mode)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk

    // setup then access; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        v = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) begin chk(0, 1); end_sim(); end
    endtask : apb

    // bounded status poll
    task automatic poll(input logic [7:0] mask, input logic [7:0] val);
        int n;
        for (n = 0; n < 100; n++) begin
            apb(0, clock_mode_pkg::OFS_STATUS, 0);
            if ((v[7:0] & mask) === val) break;
        end
        chk(v[7:0] & mask, val);
        if (n >= 100) end_sim();
    endtask : poll

    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    task automatic t_reset;
        logic [11:0] ofs[6] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                                12'h010, 12'h014};
        logic [7:0] exp[6] = '{8'h04, 8'h00, 8'h00, 8'h10, 8'h80, 8'h00};
        foreach (ofs[i]) begin
            apb(0, ofs[i], 0);
            chk(v, {24'h0, exp[i]});
        end
        chk(combined_trim_value, 9'h100);
    endtask : t_reset

    // trim with a doubled reference divider, then restore it
    task automatic t_trim;
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'h0C);
        apb(1, clock_mode_pkg::OFS_COARSE_TRIM, 32'hFF);
        apb(1, clock_mode_pkg::OFS_FINE_TRIM, 32'h01);
        settle();
        chk(combined_trim_value, 9'h1FF);
        chk(loop_drive.ref_div_log2, 3'h1);
        apb(1, clock_mode_pkg::OFS_COARSE_TRIM, 32'h00);
        apb(1, clock_mode_pkg::OFS_FINE_TRIM, 32'h00);
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'h04);
        settle();
        chk(combined_trim_value, 9'h000);
        chk(loop_drive.ref_div_log2, 3'h0);
    endtask : t_trim

    task automatic t_internal;
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'h44);
        poll(8'h0C, 8'h04);
        chk(mode, clock_mode_pkg::loop_bypassed_internal);
        chk(loop_drive.fll_enable, 1);
        fll_lock_pin <= 1;
        poll(8'h40, 8'h40);
        apb(1, clock_mode_pkg::OFS_CONTROL_TWO, 32'h08);
        settle();
        chk(mode, clock_mode_pkg::low_power_internal);
    endtask : t_internal

    task automatic t_to_pll;
        apb(1, clock_mode_pkg::OFS_CONTROL_TWO, 32'h36);
        settle();
        chk({ext_ref_on, high_range, high_gain_select, crystal_select,
             bus_divider}, 6'b111100);
        osc_init_pin <= 1;
        poll(8'h02, 8'h02);
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'hB8);
        poll(8'h10, 8'h00);
        chk(ref_is_internal, 0);
        poll(8'h0C, 8'h08);
        chk(loop_drive.ref_div_log2, 3'h7);
        apb(1, clock_mode_pkg::OFS_CONTROL_TWO, 32'h3E);
        settle();
        chk(mode, clock_mode_pkg::low_power_external);
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'h98);
        apb(1, clock_mode_pkg::OFS_CONTROL_THREE, 32'h44);
        settle();
        chk(loop_drive.ref_div_log2, 3'h7);
        apb(1, clock_mode_pkg::OFS_CONTROL_TWO, 32'h36);
        poll(8'h20, 8'h20);
        chk(mode, clock_mode_pkg::pll_bypassed_external);
        chk({loop_drive.pll_enable, loop_drive.loop_select,
             loop_drive.fll_enable}, 3'b110);
        chk({loop_drive.ref_div_log2, loop_drive.multiply}, 9'o320);
        pll_lock_pin <= 1;
        poll(8'h40, 8'h40);
        apb(1, clock_mode_pkg::OFS_CONTROL_ONE, 32'h18);
        poll(8'h0C, 8'h0C);
        chk(main_clock_select, 2'h3);
        chk(mode, clock_mode_pkg::pll_engaged_external);
    endtask : t_to_pll

    task automatic t_bus;
        apb(1, 12'h018, 32'hFF);
        chk(er, 1);
        apb(0, 12'h018, 0);
        chk({er, v}, {1'b1, 32'h0});
        apb(1, clock_mode_pkg::OFS_CONTROL_TWO, 32'hF6);
        settle();
        chk({bus_divider, bus_div_log2}, 5'b11100);
    endtask : t_bus

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_trim();
        t_internal();
        t_to_pll();
        t_bus();
        end_sim();
    end
endmodule : tb_top

// ### verilog/clock_mode_pkg.sv
// clock mode sequencer constants, register layout and carrier types
// assumes a 25 MHz pclk and an APB master with 32-bit data
// How it works
// - clock source status: 00 loop output, 10 external, 11 phase-locked loop
// - control one bits 7:6 pick source: 00 loop output, 10 external reference
// - control one bits 5:3 divide reference; 111 gives 128, 011 gives 8
// - control three bits 3:0 set multiplier; 0100 multiplies by 16
// - control three bit 6 set picks phase-locked loop, clear frequency loop
// - status bit 5 sets once phase-locked loop really sources loop clock
// - status bit 6 shows lock of selected loop, again after reference change
// - bypassed internal mode keeps frequency loop enabled and running while control three bit 6 is clear
// - low-power external disables both loops; loop fields only preload
// - control two bit 3 in bypassed external enters low power; clear leaves
// - status bit 1 sets once chosen crystal finished initializing
// - status bit 4 reads 0 external reference, 1 internal reference
// - clearing control one bit 2 makes external clock the loop reference
// - control two: bus divider 7:6, range 5, gain 4, crystal 2, enable 1
// - bus clock is main output divided by two, after bus divider
// - software goes straight to low power after bypassed external, no steps
// - trim value is nine bits: coarse byte on top, fine bit lowest
// - after reset trim value is 0x100: coarse 0x80, fine 0
// - larger trim lengthens internal reference period, lowering frequency

package clock_mode_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_CONTROL_ONE   = 12'h000;
    localparam logic [11:0] OFS_CONTROL_TWO   = 12'h004;
    localparam logic [11:0] OFS_CONTROL_THREE = 12'h008;
    localparam logic [11:0] OFS_STATUS        = 12'h00C;
    localparam logic [11:0] OFS_COARSE_TRIM   = 12'h010;
    localparam logic [11:0] OFS_FINE_TRIM     = 12'h014;

    // reset values: reset lands in loop engaged internal
    localparam logic [7:0] RST_CONTROL_ONE   = 8'h04;
    localparam logic [7:0] RST_CONTROL_TWO   = 8'h00;
    localparam logic [7:0] RST_CONTROL_THREE = 8'h00;
    localparam logic [7:0] RST_COARSE_TRIM   = 8'h80;
    localparam logic       RST_FINE_TRIM     = 1'b0;

    // clock select and clock source encodings
    localparam logic [1:0] SRC_LOOP     = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_PLL      = 2'h3;

    // status bit positions
    localparam int ST_OSC_READY  = 1;
    localparam int ST_REF_SOURCE = 4;
    localparam int ST_LOOP_SRC   = 5;
    localparam int ST_LOCK       = 6;

    // source switch settle time
    localparam int PCLK_HZ         = 25_000_000;
    localparam int SWITCH_SETTLE_NS = 200;
    localparam int SWITCH_CYCLES   =
        (SWITCH_SETTLE_NS * (PCLK_HZ / 1_000_000) + 999) / 1000;

    typedef struct packed {
        logic [1:0] clock_select;
        logic [2:0] reference_divider;
        logic       internal_ref_select;
        logic [1:0] spare;
    } control_one_t;

    typedef struct packed {
        logic [1:0] bus_divider;
        logic       high_range;
        logic       high_gain_select;
        logic       low_power_bypass;
        logic       crystal_select;
        logic       ext_ref_enable;
        logic       spare;
    } control_two_t;

    typedef struct packed {
        logic       spare_hi;
        logic       loop_select;
        logic [1:0] spare;
        logic [3:0] multiplier_field;
    } control_three_t;

    // settings actually applied to the analog loops
    typedef struct packed {
        logic       fll_enable;
        logic       pll_enable;
        logic       loop_select;
        logic [2:0] ref_div_log2;
        logic [5:0] multiply;
    } loop_drive_t;

    typedef enum logic [7:0] {
        loop_engaged_internal  = 8'h01,
        loop_engaged_external  = 8'h02,
        loop_bypassed_internal = 8'h04,
        loop_bypassed_external = 8'h08,
        pll_engaged_external   = 8'h10,
        pll_bypassed_external  = 8'h20,
        low_power_internal     = 8'h40,
        low_power_external     = 8'h80
    } clock_mode_t;

endpackage : clock_mode_pkg

// ### verilog/clock_mode_sequencer.sv
// clock mode sequencer: control registers, mode decode, settled status
// and trim value, reached over APB
// assumes loop lock and crystal ready arrive asynchronously from the
// analog side and that the analog muxes follow the settled selections
`timescale 1ns/1ps

module clock_mode_sequencer #(
    parameter int SETTLE_CYCLES = clock_mode_pkg::SWITCH_CYCLES
) (
    // clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // analog status pins
    input  wire logic                         fll_lock_pin,
    input  wire logic                         pll_lock_pin,
    input  wire logic                         osc_init_pin,
    // analog loop and oscillator controls
    output clock_mode_pkg::loop_drive_t       loop_drive,
    output logic                              ext_ref_on,
    output logic                              high_range,
    output logic                              high_gain_select,
    output logic                              crystal_select,
    // clock muxes and dividers
    output logic      [1:0]                   main_clock_select,
    output logic                              ref_is_internal,
    output logic      [1:0]                   bus_divider,
    output logic      [2:0]                   bus_div_log2,
    // internal reference trim and mode
    output logic      [8:0]                   combined_trim_value,
    output clock_mode_pkg::clock_mode_t       mode
);

    clock_mode_pkg::control_one_t   ctl_one;
    clock_mode_pkg::control_two_t   ctl_two;
    clock_mode_pkg::control_three_t ctl_three;
    logic [7:0] coarse_trim_register;
    logic       fine_trim_bit;
    clock_mode_pkg::clock_mode_t next_mode;

    // apb decode
    wire setup_phase = psel && !penable;
    wire access      = psel && penable;
    wire hit_one     = (paddr == clock_mode_pkg::OFS_CONTROL_ONE);
    wire hit_two     = (paddr == clock_mode_pkg::OFS_CONTROL_TWO);
    wire hit_three   = (paddr == clock_mode_pkg::OFS_CONTROL_THREE);
    wire hit_status  = (paddr == clock_mode_pkg::OFS_STATUS);
    wire hit_coarse  = (paddr == clock_mode_pkg::OFS_COARSE_TRIM);
    wire hit_fine    = (paddr == clock_mode_pkg::OFS_FINE_TRIM);
    wire mapped      = hit_one || hit_two || hit_three || hit_status ||
                       hit_coarse || hit_fine;
    wire wr_lane0    = access && pwrite && pstrb[0];
    wire [7:0] wbyte = pwdata[7:0];

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // control registers; only byte lane 0 carries data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_one <= clock_mode_pkg::RST_CONTROL_ONE;
        else if (wr_lane0 && hit_one)
            ctl_one <= wbyte;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_two <= clock_mode_pkg::RST_CONTROL_TWO;
        else if (wr_lane0 && hit_two)
            ctl_two <= wbyte;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_three <= clock_mode_pkg::RST_CONTROL_THREE;
        else if (wr_lane0 && hit_three)
            ctl_three <= wbyte;
    end

    // nine-bit trim, coarse byte above the fine bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_trim_register <= clock_mode_pkg::RST_COARSE_TRIM;
            fine_trim_bit        <= clock_mode_pkg::RST_FINE_TRIM;
        end else begin
            if (wr_lane0 && hit_coarse)
                coarse_trim_register <= wbyte;
            if (wr_lane0 && hit_fine)
                fine_trim_bit <= wbyte[0];
        end
    end

    // larger value lengthens the analog oscillator period
    assign combined_trim_value = {coarse_trim_register, fine_trim_bit};

    // three-stage pin synchronisers; a level counts once stages 2 and 3 agree
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] pin_level;
    wire  [2:0] pins = {osc_init_pin, pll_lock_pin, fll_lock_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a    <= 3'h0;
            sync_b    <= 3'h0;
            sync_c    <= 3'h0;
            pin_level <= 3'h0;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
            sync_c <= sync_b;
            pin_level <= (sync_b & sync_c) | (pin_level & (sync_b | sync_c));
        end
    end

    wire fll_locked = pin_level[0];
    wire pll_locked = pin_level[1];
    wire osc_done   = pin_level[2];

    // settled selections; status follows only a completed switch
    logic [1:0] clk_target;
    logic [1:0] clk_status;
    logic [0:0] ref_status;
    logic [0:0] loop_status;

    wire low_power_req = ctl_two.low_power_bypass &&
                         (ctl_one.clock_select != clock_mode_pkg::SRC_LOOP);

    // loop output is reported by which loop actually feeds it
    assign clk_target =
        (ctl_one.clock_select == clock_mode_pkg::SRC_LOOP) ?
            (loop_status[0] ? clock_mode_pkg::SRC_PLL
                            : clock_mode_pkg::SRC_LOOP) :
            ctl_one.clock_select;

    switch_settle #(
        .WIDTH       (2),
        .CYCLES      (SETTLE_CYCLES),
        .RESET_VALUE (clock_mode_pkg::SRC_LOOP)
    ) clk_switch (
        .pclk    (pclk),
        .presetn (presetn),
        .target  (clk_target),
        .current (clk_status)
    );

    switch_settle #(
        .WIDTH       (1),
        .CYCLES      (SETTLE_CYCLES),
        .RESET_VALUE (1'b1)
    ) ref_switch (
        .pclk    (pclk),
        .presetn (presetn),
        .target  (ctl_one.internal_ref_select),
        .current (ref_status)
    );

    // in low power the loop source holds; the new choice is only preloaded
    logic [0:0] loop_target;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            loop_target <= 1'b0;
        else if (!low_power_req)
            loop_target <= ctl_three.loop_select;
    end

    switch_settle #(
        .WIDTH       (1),
        .CYCLES      (SETTLE_CYCLES),
        .RESET_VALUE (1'b0)
    ) loop_switch (
        .pclk    (pclk),
        .presetn (presetn),
        .target  (loop_target),
        .current (loop_status)
    );

    // mode decode
    always_comb begin
        next_mode = clock_mode_pkg::loop_engaged_internal;
        case (ctl_one.clock_select)
            clock_mode_pkg::SRC_LOOP: begin
                if (ctl_three.loop_select)
                    next_mode = clock_mode_pkg::pll_engaged_external;
                else if (ctl_one.internal_ref_select)
                    next_mode = clock_mode_pkg::loop_engaged_internal;
                else
                    next_mode = clock_mode_pkg::loop_engaged_external;
            end
            clock_mode_pkg::SRC_INTERNAL: begin
                if (ctl_two.low_power_bypass)
                    next_mode = clock_mode_pkg::low_power_internal;
                else
                    next_mode = clock_mode_pkg::loop_bypassed_internal;
            end
            default: begin
                if (ctl_two.low_power_bypass)
                    next_mode = clock_mode_pkg::low_power_external;
                else if (ctl_three.loop_select)
                    next_mode = clock_mode_pkg::pll_bypassed_external;
                else
                    next_mode = clock_mode_pkg::loop_bypassed_external;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode <= clock_mode_pkg::loop_engaged_internal;
        else
            mode <= next_mode;
    end

    wire in_low_power = (next_mode == clock_mode_pkg::low_power_internal) ||
                        (next_mode == clock_mode_pkg::low_power_external);

    // loop drive; dividers and multiplier only reach the loops outside low
    // power, so writes there just preload the next loop mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_drive.fll_enable   <= 1'b1;
            loop_drive.pll_enable   <= 1'b0;
            loop_drive.loop_select  <= 1'b0;
            loop_drive.ref_div_log2 <= 3'h0;
            loop_drive.multiply     <= 6'h00;
        end else begin
            // frequency loop also runs while bypassed internally, unless control three bit 6 has switched to the phase-locked loop
            loop_drive.fll_enable  <= !in_low_power && !loop_status[0];
            loop_drive.pll_enable  <= !in_low_power && loop_target[0];
            loop_drive.loop_select <= loop_status[0];
            if (!in_low_power) begin
                loop_drive.ref_div_log2 <= ctl_one.reference_divider;
                loop_drive.multiply <= {ctl_three.multiplier_field, 2'b00};
            end
        end
    end

    // lock of the loop in use; drops while the reference is changing over
    logic lock_status;
    wire  ref_moving = (ctl_one.internal_ref_select != ref_status[0]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lock_status <= 1'b0;
        else if (in_low_power || ref_moving ||
                 (loop_target[0] != loop_status[0]))
            lock_status <= 1'b0;
        else
            lock_status <= loop_status[0] ? pll_locked : fll_locked;
    end

    // crystal ready once the selected crystal reports initialised
    logic osc_ready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_ready <= 1'b0;
        else
            osc_ready <= osc_done && ctl_two.crystal_select &&
                         ctl_two.ext_ref_enable;
    end

    wire [7:0] status_byte = {1'b0, lock_status, loop_status[0],
                              ref_status[0], clk_status, osc_ready, 1'b0};

    // oscillator and mux outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ref_on        <= 1'b0;
            high_range        <= 1'b0;
            high_gain_select  <= 1'b0;
            crystal_select    <= 1'b0;
            bus_divider       <= 2'h0;
            bus_div_log2      <= 3'h1;
            main_clock_select <= clock_mode_pkg::SRC_LOOP;
            ref_is_internal   <= 1'b1;
        end else begin
            ext_ref_on        <= ctl_two.ext_ref_enable;
            high_range        <= ctl_two.high_range;
            high_gain_select  <= ctl_two.high_gain_select;
            crystal_select    <= ctl_two.crystal_select;
            bus_divider       <= ctl_two.bus_divider;
            // main output over bus divider, then a fixed halving
            bus_div_log2      <= {1'b0, ctl_two.bus_divider} + 3'h1;
            main_clock_select <= clk_status;
            ref_is_internal   <= ref_status[0];
        end
    end

    // read data captured in setup so it stands through the access phase
    wire [7:0] read_byte =
        hit_one    ? ctl_one :
        hit_two    ? ctl_two :
        hit_three  ? ctl_three :
        hit_status ? status_byte :
        hit_coarse ? coarse_trim_register :
        hit_fine   ? {7'h00, fine_trim_bit} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata <= {24'h000000, read_byte};
    end

    // low power takes effect on the very write that sets it, no extra step

endmodule : clock_mode_sequencer

// ### verilog/switch_settle.sv
// holds a source selection until a requested change has settled
// assumes target comes from logic on the same clock
`timescale 1ns/1ps

module switch_settle #(
    parameter int          WIDTH  = 2,
    parameter int          CYCLES = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // request and settled result
    input  wire logic [WIDTH-1:0] target,
    output logic      [WIDTH-1:0] current
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;
    logic [WIDTH-1:0] pending;
    wire           differs = (target != current);
    wire           moved   = (target != pending);
    wire           done    = differs && !moved && (count == LAST);

    // a new request restarts the wait, so the mux never sees a half switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count   <= '0;
            pending <= RESET_VALUE;
            current <= RESET_VALUE;
        end else begin
            pending <= target;
            count   <= (!differs || moved || done) ? '0 : count + 1'b1;
            if (done)
                current <= pending;
        end
    end

endmodule : switch_settle
